// >>> design/gpt_map.svh
// register offsets, field positions, masks and reset values of the timer
`ifndef GPT_MAP_SVH
`define GPT_MAP_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define GPT_OFS_CTL1      5'h00
`define GPT_OFS_CTL2      5'h01
`define GPT_OFS_SLAVE     5'h02
`define GPT_OFS_IRQ_EN    5'h03
`define GPT_OFS_STATUS    5'h04
`define GPT_OFS_EVENT     5'h05
`define GPT_OFS_CHMODE1   5'h06
`define GPT_OFS_CHOUT     5'h09
`define GPT_OFS_CNT_HI    5'h0A
`define GPT_OFS_CNT_LO    5'h0B
`define GPT_OFS_DIV_EXP   5'h0C
`define GPT_OFS_RELOAD_HI 5'h0D
`define GPT_OFS_RELOAD_LO 5'h0E
`define GPT_OFS_CMP1_HI   5'h0F

// ****************************************************************
// field positions
// ****************************************************************
`define GPT_CTL1_RELOAD_PRE 7
`define GPT_CTL1_SINGLE     3
`define GPT_CTL1_REQ_SRC    2
`define GPT_CTL1_INHIBIT    1
`define GPT_CTL1_COUNT_ON   0
`define GPT_SLAVE_SYNC      7
`define GPT_EV_SW_UPDATE    0
`define GPT_EV_TRIGGER      6
`define GPT_FLAG_UPDATE     0
`define GPT_FLAG_TRIGGER    6

// ****************************************************************
// codes of the master output, slave controller and trigger select fields
// ****************************************************************
`define GPT_MOS_SW_UPDATE   3'h0
`define GPT_MOS_ENABLE      3'h1
`define GPT_MOS_UPDATE      3'h2
`define GPT_SMS_OFF         3'h0
`define GPT_SMS_RESET       3'h4
`define GPT_SMS_GATED       3'h5
`define GPT_SMS_TRIGGER     3'h6
`define GPT_SMS_EXT_CLOCK   3'h7
`define GPT_TS_INTERNAL_TRIGGER_ZERO         3'h0
`define GPT_TS_INTERNAL_TRIGGER_THREE         3'h3
`define GPT_TS_EDGE1        3'h4
`define GPT_TS_IN1          3'h5
`define GPT_TS_IN2          3'h6
`define GPT_TS_EXT          3'h7

// ****************************************************************
// writable bit masks and reset values
// ****************************************************************
`define GPT_MASK_CTL1       8'h8F
`define GPT_MASK_CTL2       8'h70
`define GPT_MASK_SLAVE      8'hF7
`define GPT_MASK_FLAGS      8'h4F
`define GPT_MASK_CHMODE     8'h70
`define GPT_MASK_CHOUT      8'h3F
`define GPT_RST_BYTE        8'h00
`define GPT_RST_RELOAD      16'hFFFF

`endif

// >>> design/gpt_pkg.sv
// types shared by the timer and its surroundings
package gpt_pkg;

   // ****************************************************************
   // trigger sources and interrupt requests
   // ****************************************************************
   typedef struct packed {
      logic internal_trigger_zero;
      logic internal_trigger_three;
      logic chan1_edge_detect;
      logic chan1_filtered_input;
      logic chan2_filtered_input;
      logic filtered_external_trigger;
   } gpt_trig_s;

   typedef struct packed {
      logic trigger;
      logic cc3;
      logic cc2;
      logic cc1;
      logic update;
   } gpt_irq_s;

   // ****************************************************************
   // whole timer state
   // ****************************************************************
   typedef struct packed {
      logic [7:0]       ctl1;
      logic [7:0]       ctl2;
      logic [7:0]       slave;
      logic [7:0]       irq_en;
      logic [7:0]       flags;
      logic [7:0]       chout;
      logic [2:0][7:0]  chmode;
      logic [15:0]      cnt;
      logic [15:0]      div_cnt;
      logic [15:0]      reload_pre;
      logic [15:0]      reload_act;
      logic [2:0][15:0] cmp;
      logic [3:0]       exp_pre;
      logic [3:0]       exp_act;
      logic [7:0]       hi_tmp;
      logic [2:0]       ref_wave;
      logic [2:0]       chan_out;
      logic             trg_prev;
      logic             trg_dly;
      logic             en_prev;
      logic             trigger_out;
      logic [7:0]       rdata;
   } gpt_state_s;

endpackage

// >>> design/gpt_timer.sv
// general purpose 16-bit timer with slave controller and trigger output
`timescale 1ns/100ps
`include "gpt_map.svh"

module gpt_timer (
   input  wire logic              ref_clk,
   input  wire logic              srst,
   input  wire logic [4:0]        reg_addr,
   input  wire logic [7:0]        reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic [7:0]             reg_rdata,
   input  gpt_pkg::gpt_trig_s     trigger_src,
   output logic                   trigger_out,
   output logic [2:0]             chan_out,
   output gpt_pkg::gpt_irq_s      irq
);
   import gpt_pkg::*;

   gpt_state_s s;
   gpt_state_s next_s;

   logic       trg_raw;
   logic       trg;
   logic       rise;
   logic       fall;
   logic [2:0] slave_controller_select;
   logic       wr_hit;
   logic [7:0] ev;
   logic       slave_rst;
   logic       div_in;
   logic       en_sig;
   logic [15:0] limit;
   logic       tick;
   logic       ovf;
   logic       reinit;
   logic       update_event;
   logic       inhibit;
   logic [2:0] match;
   logic [4:0] rofs;

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      next_s = s;
      slave_controller_select = s.slave[2:0];
      inhibit = s.ctl1[`GPT_CTL1_INHIBIT];
      wr_hit = reg_wr;
      rofs = 5'h00;

      // trigger select and sync delay
      case (s.slave[6:4])
         `GPT_TS_INTERNAL_TRIGGER_ZERO:  trg_raw = trigger_src.internal_trigger_zero;
         `GPT_TS_INTERNAL_TRIGGER_THREE:  trg_raw = trigger_src.internal_trigger_three;
         `GPT_TS_EDGE1: trg_raw = trigger_src.chan1_edge_detect;
         `GPT_TS_IN1:   trg_raw = trigger_src.chan1_filtered_input;
         `GPT_TS_IN2:   trg_raw = trigger_src.chan2_filtered_input;
         `GPT_TS_EXT:   trg_raw = trigger_src.filtered_external_trigger;
         default:       trg_raw = 1'b0;
      endcase
      trg = s.slave[`GPT_SLAVE_SYNC] ? s.trg_dly : trg_raw;
      next_s.trg_dly = trg_raw;
      next_s.trg_prev = trg;
      rise = trg & ~s.trg_prev;
      fall = ~trg & s.trg_prev;

      // software register writes
      ev = `GPT_RST_BYTE;
      if (wr_hit) begin
         case (reg_addr)
            `GPT_OFS_CTL1:
               next_s.ctl1 = reg_wdata & `GPT_MASK_CTL1;
            `GPT_OFS_CTL2:    next_s.ctl2 = reg_wdata & `GPT_MASK_CTL2;
            `GPT_OFS_SLAVE:   next_s.slave = reg_wdata & `GPT_MASK_SLAVE;
            `GPT_OFS_IRQ_EN:  next_s.irq_en = reg_wdata & `GPT_MASK_FLAGS;
            `GPT_OFS_STATUS:  next_s.flags = s.flags & reg_wdata;
            `GPT_OFS_EVENT:   ev = reg_wdata & `GPT_MASK_FLAGS;
            `GPT_OFS_CHOUT:   next_s.chout = reg_wdata & `GPT_MASK_CHOUT;
            `GPT_OFS_CNT_HI:  next_s.cnt[15:8] = reg_wdata;
            `GPT_OFS_CNT_LO:  next_s.cnt[7:0] = reg_wdata;
            `GPT_OFS_DIV_EXP: next_s.exp_pre = reg_wdata[3:0];
            `GPT_OFS_RELOAD_LO: begin
               next_s.reload_pre = {s.hi_tmp, reg_wdata};
               if (!s.ctl1[`GPT_CTL1_RELOAD_PRE]) begin
                  next_s.reload_act = {s.hi_tmp, reg_wdata};
               end
            end
            default: begin
               // reload and compare high bytes wait in a holding byte so
               // those 16-bit values never apply half written
               if (reg_addr == `GPT_OFS_RELOAD_HI) begin
                  next_s.hi_tmp = reg_wdata;
               end
               for (int i = 0; i < 3; i++) begin
                  if (reg_addr == `GPT_OFS_CHMODE1 + 5'(i)) begin
                     next_s.chmode[i] = reg_wdata & `GPT_MASK_CHMODE;
                  end
                  if (reg_addr == `GPT_OFS_CMP1_HI + 5'(2 * i)) begin
                     next_s.hi_tmp = reg_wdata;
                  end
                  if (reg_addr == `GPT_OFS_CMP1_HI + 5'(2 * i + 1)) begin
                     next_s.cmp[i] = {s.hi_tmp, reg_wdata};
                  end
               end
            end
         endcase
      end

      // slave controller
      slave_rst = (slave_controller_select == `GPT_SMS_RESET) && rise;
      if ((slave_controller_select == `GPT_SMS_TRIGGER) && rise) begin
         next_s.ctl1[`GPT_CTL1_COUNT_ON] = 1'b1;
      end
      // divider input is the master clock qualified per mode
      case (slave_controller_select)
         `GPT_SMS_GATED:     div_in = s.ctl1[0] & trg;
         `GPT_SMS_EXT_CLOCK: div_in = s.ctl1[0] & rise;
         `GPT_SMS_OFF, `GPT_SMS_RESET, `GPT_SMS_TRIGGER:
                             div_in = s.ctl1[0];
         default:            div_in = 1'b0;
      endcase
      en_sig = s.ctl1[0] | ((slave_controller_select == `GPT_SMS_GATED) & trg);
      next_s.en_prev = en_sig;

      // divider and counter
      limit = 16'((17'h00001 << s.exp_act) - 17'h00001);
      tick = div_in && (s.div_cnt == limit);
      if (div_in) begin
         next_s.div_cnt = tick ? 16'h0000 : s.div_cnt + 16'h0001;
      end
      ovf = tick && (s.cnt == s.reload_act);
      if (tick) begin
         next_s.cnt = ovf ? 16'h0000 : s.cnt + 16'h0001;
      end
      reinit = ev[`GPT_EV_SW_UPDATE] | slave_rst;
      if (reinit) begin
         next_s.cnt = 16'h0000;
         next_s.div_cnt = 16'h0000;
      end

      // update event and shadow loads
      update_event = (ovf | reinit) & ~inhibit;
      if (update_event) begin
         next_s.exp_act = s.exp_pre;
         if (s.ctl1[`GPT_CTL1_RELOAD_PRE]) begin
            next_s.reload_act = s.reload_pre;
         end
         if (s.ctl1[`GPT_CTL1_SINGLE]) begin
            next_s.ctl1[`GPT_CTL1_COUNT_ON] = 1'b0;
         end
      end

      // sticky flags, set wins over the clear written above
      if ((ovf & ~inhibit) | (reinit & ~inhibit
            & ~s.ctl1[`GPT_CTL1_REQ_SRC])) begin
         next_s.flags[`GPT_FLAG_UPDATE] = 1'b1;
      end
      if (((slave_controller_select != `GPT_SMS_OFF) && (rise || (fall
            && (slave_controller_select == `GPT_SMS_GATED)))) || ev[`GPT_EV_TRIGGER]) begin
         next_s.flags[`GPT_FLAG_TRIGGER] = 1'b1;
      end

      // compare channels: active-high reference, polarity last
      for (int i = 0; i < 3; i++) begin
         match[i] = tick && (next_s.cnt == s.cmp[i]);
         if (match[i] || ev[i + 1]) begin
            next_s.flags[i + 1] = 1'b1;
         end
         case (s.chmode[i][6:4])
            3'h1: next_s.ref_wave[i] = match[i] | s.ref_wave[i];
            3'h2: next_s.ref_wave[i] = ~match[i] & s.ref_wave[i];
            3'h3: next_s.ref_wave[i] = match[i] ^ s.ref_wave[i];
            3'h4: next_s.ref_wave[i] = 1'b0;
            3'h5: next_s.ref_wave[i] = 1'b1;
            3'h6: next_s.ref_wave[i] = next_s.cnt < s.cmp[i];
            3'h7: next_s.ref_wave[i] = !(next_s.cnt < s.cmp[i]);
            default: next_s.ref_wave[i] = s.ref_wave[i];
         endcase
         next_s.chan_out[i] = s.chout[2 * i]
            & (s.ref_wave[i] ^ s.chout[2 * i + 1]);
      end

      // trigger output
      case (s.ctl2[6:4])
         `GPT_MOS_SW_UPDATE: next_s.trigger_out = reinit;
         `GPT_MOS_ENABLE: begin
            // gated enable reaches slaves a cycle late unless sync delay
            if ((slave_controller_select == `GPT_SMS_GATED) && !s.slave[`GPT_SLAVE_SYNC]) begin
               next_s.trigger_out = s.en_prev;
            end else begin
               next_s.trigger_out = en_sig;
            end
         end
         `GPT_MOS_UPDATE:    next_s.trigger_out = update_event;
         default:            next_s.trigger_out = 1'b0;
      endcase

      // read data, registered one cycle after the strobe
      next_s.rdata = 8'h00;
      if (reg_rd) begin
         case (reg_addr)
            `GPT_OFS_CTL1:      next_s.rdata = s.ctl1;
            `GPT_OFS_CTL2:      next_s.rdata = s.ctl2;
            `GPT_OFS_SLAVE:     next_s.rdata = s.slave;
            `GPT_OFS_IRQ_EN:    next_s.rdata = s.irq_en;
            `GPT_OFS_STATUS:    next_s.rdata = s.flags;
            `GPT_OFS_CHOUT:     next_s.rdata = s.chout;
            `GPT_OFS_CNT_HI:    next_s.rdata = s.cnt[15:8];
            `GPT_OFS_CNT_LO:    next_s.rdata = s.cnt[7:0];
            `GPT_OFS_DIV_EXP:   next_s.rdata = {4'h0, s.exp_pre};
            `GPT_OFS_RELOAD_HI: next_s.rdata = s.reload_pre[15:8];
            `GPT_OFS_RELOAD_LO: next_s.rdata = s.reload_pre[7:0];
            default: begin
               for (int i = 0; i < 3; i++) begin
                  rofs = `GPT_OFS_CMP1_HI + 5'(2 * i);
                  if (reg_addr == `GPT_OFS_CHMODE1 + 5'(i)) begin
                     next_s.rdata = s.chmode[i];
                  end
                  if (reg_addr == rofs) begin
                     next_s.rdata = s.cmp[i][15:8];
                  end
                  if (reg_addr == rofs + 5'h01) begin
                     next_s.rdata = s.cmp[i][7:0];
                  end
               end
            end
         endcase
      end
   end

   // ****************************************************************
   // state register
   // ****************************************************************
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         s <= '0;
         s.reload_pre <= `GPT_RST_RELOAD;
         s.reload_act <= `GPT_RST_RELOAD;
      end else begin
         s <= next_s;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   assign reg_rdata = s.rdata;
   assign trigger_out = s.trigger_out;
   assign chan_out = s.chan_out;
   // each request gated by its own enable bit
   assign irq.update = s.flags[0] & s.irq_en[0];
   assign irq.cc1 = s.flags[1] & s.irq_en[1];
   assign irq.cc2 = s.flags[2] & s.irq_en[2];
   assign irq.cc3 = s.flags[3] & s.irq_en[3];
   assign irq.trigger = s.flags[6] & s.irq_en[6];

endmodule

// >>> verification/gpt_timer_checker.sv
// port checker for the general purpose timer
`timescale 1ns/100ps
module gpt_timer_checker (
   input wire logic          ref_clk,
   input wire logic          srst,
   input wire logic [4:0]    reg_addr,
   input wire logic [7:0]    reg_wdata,
   input wire logic          reg_wr,
   input wire logic          reg_rd,
   input wire logic [7:0]    reg_rdata,
   input gpt_pkg::gpt_trig_s trigger_src,
   input wire logic          trigger_out,
   input wire logic [2:0]    chan_out,
   input gpt_pkg::gpt_irq_s  irq
);
   import gpt_pkg::*;
   // ****************************************************************
   // shadows of software-owned bits
   // ****************************************************************
   logic [7:0] c1, c2, sl, en, co;
   logic       ev;
   assign ev = reg_wr && reg_addr == 5'h05;
   // hardware may clear count_on; only the written value is kept here
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         {c1, c2, sl, en, co} <= 40'h0;
      end else if (reg_wr) begin
         case (reg_addr)
            5'h00: c1 <= reg_wdata;
            5'h01: c2 <= reg_wdata;
            5'h02: sl <= reg_wdata;
            5'h03: en <= reg_wdata;
            5'h09: co <= reg_wdata;
            default: ;
         endcase
      end
   end
   // ****************************************************************
   // assertions
   // ****************************************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);
   chk_read_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data outside its slot");
   chk_irq_gated: assert property ((irq & ~{en[6], en[3:0]}) == 5'h00)
      else $error("request without its enable");
   chk_soft_trig: assert property (ev && reg_wdata[6] && en[6] |=> ##[0:1] irq.trigger)
      else $error("software trigger raised no request");
   chk_soft_cc1: assert property (ev && reg_wdata[1] && en[1] |=> ##[0:1] irq.cc1)
      else $error("software compare event raised no request");
   chk_sw_update: assert property (ev && reg_wdata[0] && en[0] && c1[2:1] == 2'h0
      |=> ##[0:1] irq.update)
      else $error("software update raised no request");
   // stopped counter cannot overflow, so any flag would come from the write
   chk_urs_quiet: assert property (ev && reg_wdata[0] && c1[2] && !c1[0] &&
      sl[2:0] == 3'h0 && !irq.update |=> !irq.update [*2])
      else $error("update request despite overflow-only source");
   chk_inhibit_quiet: assert property (ev && reg_wdata[0] && c1[1] && !c1[0] &&
      sl[2:0] == 3'h0 && !irq.update |=> !irq.update [*2])
      else $error("update request while updates inhibited");
   chk_ug_trigger_out: assert property (ev && reg_wdata[0] && c2[6:4] == 3'h0
      |=> ##[0:1] trigger_out)
      else $error("no trigger output on software update");
   chk_en_trigger_out: assert property (reg_wr && reg_addr == 5'h00 && reg_wdata[0] &&
      c2[6:4] == 3'h1 |=> ##[0:1] trigger_out)
      else $error("enable not sent on trigger output");
   chk_chan_enable: assert property (chan_out[0] |-> co[0] || $past(co[0]))
      else $error("channel output driven while disabled");
endmodule

bind gpt_timer gpt_timer_checker u_chk (.ref_clk, .srst, .reg_addr, .reg_wdata,
   .reg_wr, .reg_rd, .reg_rdata, .trigger_src, .trigger_out, .chan_out, .irq);

// >>> verification/gpt_trig_model.sv
// trigger sources as driven by neighbouring timers
`timescale 1ns/100ps
module gpt_trig_model (
   input  wire logic [2:0]   sel,
   input  wire logic         level,
   output gpt_pkg::gpt_trig_s trig
);
   import gpt_pkg::*;
   logic [5:0] idx;
   // unselected sources sit at the inverse level, so a wrong select
   // never shows the expected rising edge
   always_comb begin
      case (sel)
         3'h0: idx = 6'h20;
         3'h3: idx = 6'h10;
         3'h4: idx = 6'h08;
         3'h5: idx = 6'h04;
         3'h6: idx = 6'h02;
         default: idx = 6'h01;
      endcase
      trig = gpt_trig_s'((idx & {6{level}}) | (~idx & {6{~level}}));
   end
endmodule

// >>> verification/gpt_timer_tb.sv
// self-checking bench of the general purpose timer
`timescale 1ns/100ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_mismatch++; \
   $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
module gpt_timer_tb;
   import gpt_pkg::*;
   logic ref_clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, level = 1'b0;
   logic [4:0] addr = 5'h00;
   logic [7:0] wdata = 8'h00, rdata, v;
   logic [2:0] sel = 3'h0, chan;
   logic       tout;
   logic [15:0] c;
   gpt_trig_s  trig;
   gpt_irq_s   irq;
   int         n_mismatch = 0, checks_done = 0, cycles = 0, n1, n2, n3;
   int         n_tout = 0;
   logic [2:0] tsl [6] = '{3'h0, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
   logic [7:0] msk [3] = '{8'h8F, 8'h70, 8'hF7};
   gpt_timer DUT (.ref_clk(ref_clk), .srst(srst), .reg_addr(addr),
      .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata),
      .trigger_src(trig), .trigger_out(tout), .chan_out(chan), .irq(irq));
   gpt_trig_model TRG (.sel(sel), .level(level), .trig(trig));
   always #5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      cycles++;
      if (tout === 1'b1) n_tout++;
      if (cycles == 20000) begin
         n_mismatch++;
         complete_run();
      end
   end
   // ****************************************************************
   // bus tasks
   // ****************************************************************
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic w(input logic [4:0] a, input logic [7:0] d);
      wr <= 1'b1; addr <= a; wdata <= d;
      @(posedge ref_clk);
      wr <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic r(input logic [4:0] a, output logic [7:0] d);
      rd <= 1'b1; addr <= a;
      @(posedge ref_clk);
      rd <= 1'b0;
      #1 d = rdata;
      @(posedge ref_clk);
   endtask
   task automatic rdx(input logic [4:0] a, input logic [7:0] e);
      r(a, v);
      `CHK(v, e);
   endtask
   task automatic run(input int n);
      w(5'h00, 8'h01);
      cyc(n);
      w(5'h00, 8'h00);
      r(5'h0A, c[15:8]);
      r(5'h0B, c[7:0]);
   endtask
   // stop is the overflow itself, so the wait measures the period
   task automatic shot(input logic [7:0] ctl, output int n);
      w(5'h04, 8'h00);
      w(5'h00, ctl);
      n = 0;
      while (irq.update !== 1'b1 && n < 60) begin
         cyc(1);
         n++;
      end
   endtask
   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic t_regs();
      for (int i = 0; i < 3; i++) begin
         rdx(5'(i), 8'h00);
         w(5'(i), 8'hFF);
         rdx(5'(i), msk[i]);
         w(5'(i), 8'h00);
      end
      w(5'h1F, 8'hFF);
      rdx(5'h1F, 8'h00);
   endtask
   task automatic t_divider();
      w(5'h0C, 8'h00);
      w(5'h05, 8'h01);
      w(5'h0C, 8'h03);
      rdx(5'h0C, 8'h03);
      run(14);
      `CHK(c >= 15 && c <= 17, 1'b1);
      w(5'h05, 8'h01);
      rdx(5'h0B, 8'h00);
      run(30);
      `CHK(c >= 3 && c <= 5, 1'b1);
      w(5'h0C, 8'h00);
      w(5'h05, 8'h01);
   endtask
   task automatic t_reload();
      w(5'h03, 8'h01);
      w(5'h0D, 8'h00);
      w(5'h0E, 8'h03);
      w(5'h05, 8'h01);
      shot(8'h09, n1);
      `CHK(n1 < 60, 1'b1);
      rdx(5'h00, 8'h08);
      rdx(5'h0B, 8'h00);
      w(5'h00, 8'h80);
      w(5'h0D, 8'h00);
      w(5'h0E, 8'h07);
      shot(8'h89, n2);
      `CHK(n2, n1);
      shot(8'h89, n3);
      `CHK(n3, n1 + 4);
      w(5'h00, 8'h00);
   endtask
   task automatic t_flags();
      w(5'h04, 8'h00);
      w(5'h03, 8'h4F);
      w(5'h05, 8'h4E);
      `CHK(irq, 5'h1E);
      rdx(5'h04, 8'h4E);
      w(5'h03, 8'h00);
      `CHK(irq, 5'h00);
      w(5'h06, 8'h50);
      w(5'h09, 8'h01);
      cyc(2);
      `CHK(chan[0], 1'b1);
      w(5'h09, 8'h03);
      cyc(2);
      `CHK(chan[0], 1'b0);
      w(5'h03, 8'h01);
      for (int i = 0; i < 3; i++) begin
         w(5'h04, 8'h00);
         w(5'h00, (8'h04 >> i) & 8'h06);
         w(5'h05, 8'h01);
         rdx(5'h04, 8'(i / 2));
      end
   endtask
   task automatic t_master();
      n1 = n_tout;
      w(5'h05, 8'h01);
      cyc(1);
      `CHK(n_tout > n1, 1'b1);
      w(5'h01, 8'h10);
      w(5'h00, 8'h01);
      cyc(1);
      `CHK(tout, 1'b1);
      w(5'h00, 8'h00);
      cyc(1);
      `CHK(tout, 1'b0);
      w(5'h0E, 8'h03);
      w(5'h01, 8'h20);
      n1 = n_tout;
      cyc(8);
      `CHK(n_tout, n1);
      w(5'h00, 8'h01);
      cyc(8);
      `CHK(n_tout > n1, 1'b1);
      w(5'h00, 8'h00);
   endtask
   task automatic t_slave();
      level <= 1'b1;
      cyc(3);
      rdx(5'h00, 8'h00);
      for (int i = 0; i < 6; i++) begin
         level <= 1'b0;
         sel <= tsl[i];
         w(5'h00, 8'h00);
         w(5'h02, {1'b0, tsl[i], 4'h0});
         w(5'h02, {1'b0, tsl[i], 4'h6});
         level <= 1'b1;
         cyc(3);
         rdx(5'h00, 8'h01);
      end
      level <= 1'b0;
      sel <= 3'h5;
      w(5'h00, 8'h00);
      w(5'h02, 8'h50);
      w(5'h0D, 8'hFF);
      w(5'h0E, 8'hFF);
      w(5'h05, 8'h01);
      w(5'h02, 8'h55);
      w(5'h00, 8'h01);
      cyc(10);
      level <= 1'b1;
      cyc(20);
      level <= 1'b0;
      cyc(10);
      run(0);
      `CHK(c >= 17 && c <= 23, 1'b1);
      w(5'h02, 8'h50);
      w(5'h02, 8'h54);
      w(5'h00, 8'h01);
      cyc(30);
      level <= 1'b1;
      cyc(2);
      r(5'h0B, v);
      `CHK(v < 8'h0C, 1'b1);
      level <= 1'b0;
      w(5'h00, 8'h00);
      w(5'h02, 8'hD0);
      w(5'h02, 8'hD7);
      w(5'h0B, 8'h00);
      w(5'h00, 8'h01);
      repeat (5) begin
         level <= 1'b1;
         cyc(2);
         level <= 1'b0;
         cyc(2);
      end
      cyc(4);
      rdx(5'h0B, 8'h05);
      w(5'h02, 8'h00);
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge ref_clk);
      srst <= 1'b0;
      @(posedge ref_clk);
      t_regs();
      t_divider();
      t_reload();
      t_flags();
      t_master();
      t_slave();
      complete_run();
   end
endmodule
